// >>> lpm_pkg.sv
package lpm_pkg;
    // system clock period, 40 MHz
    localparam int SYS_PERIOD_NS = 25;
    // register offsets (byte addresses)
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    // low_power_ctrl field layout
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 2;
    localparam int QUAL_LSB = 2;
    localparam int QUAL_W = 6;
    localparam int QUAL_EN_BIT = 8;
    localparam int HALVE_BIT = 9;
    localparam int CTRL_USED_W = 10;
    localparam logic [CTRL_USED_W-1:0] CTRL_RESET = 10'h000;
    // status field layout
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_MODE_LSB = 4;
    localparam int STAT_PEND_BIT = 8;
    // low-power modes chosen by the mode field
    localparam logic [MODE_W-1:0] MODE_IDLE = 2'h0;
    localparam logic [MODE_W-1:0] MODE_STANDBY = 2'h1;
    localparam logic [MODE_W-1:0] MODE_HALT = 2'h2;
    // timing counts, in system clock cycles
    localparam int CNT_W = 18;
    localparam int HOLD_SHORT = 32;
    localparam int HOLD_LONG = 64;
    localparam int CLKOUT_STOP_MIN = 32;
    localparam int CLKOUT_STOP_MAX = 45;
    localparam int IDLE_RESUME = 20;
    localparam int STBY_RESUME_AWAKE = 100;
    localparam int STBY_RESUME_SLEEP = 1125;
    localparam int HALT_RESUME_RAM = 35;
    localparam int HALT_RESUME_FLASH = 1125;
    localparam int PLL_LOCK_OSC = 131072;
    localparam int OSC_START_DEFAULT = 1024;
    localparam int QUAL_BASE = 2;
    // sequencer states, gray coded in the order listed
    typedef enum logic [2:0] {
        ST_RUN = 3'h0,
        ST_HOLD = 3'h1,
        ST_STBY = 3'h3,
        ST_HALT = 3'h2,
        ST_OSC = 3'h6,
        ST_PLL = 3'h7,
        ST_RESUME = 3'h5,
        ST_IDLE = 3'h4
    } lpm_state_t;
endpackage

// >>> span_timer.sv
`timescale 1ns/1ps
// down counter: loaded with n, expire_out is high in the n-th cycle after load
module span_timer #(
    parameter int W = 18
) (
    input wire logic clk_in,
    input wire logic srst_in,
    input wire logic load_in,
    input wire logic [W-1:0] value_in,
    output logic expire_out
);
    logic [W-1:0] count_r; // remaining cycles

    // load wins over counting; stops at zero
    always_ff @(posedge clk_in)
    begin
        if (srst_in)
            count_r <= '0;
        else if (load_in)
            count_r <= value_in;
        else if (count_r != '0)
            count_r <= count_r - W'(1);
    end

    assign expire_out = (count_r == W'(1));
endmodule

// >>> low_power_mode_sequencer.sv
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module low_power_mode_sequencer
    import lpm_pkg::*;
#(
    parameter int PLL_LOCK_CYCLES = lpm_pkg::PLL_LOCK_OSC,
    parameter int OSC_START_CYCLES = lpm_pkg::OSC_START_DEFAULT
) (
    input wire logic clk_sys_in,
    input wire logic srst_in,
    input wire logic [lpm_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [lpm_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [lpm_pkg::DATA_W-1:0] reg_rdata_out,
    input wire logic idle_exec_in,
    input wire logic wake_irq_in,
    input wire logic watchdog_irq_in,
    input wire logic external_nmi_in,
    input wire logic external_reset_pin_n_in,
    input wire logic wake_pin_n_in,
    input wire logic flash_asleep_in,
    input wire logic code_in_ram_in,
    input wire logic crystal_source_in,
    output logic clock_out_pin_out,
    output logic core_clk_en_out,
    output logic periph_clk_en_out,
    output logic pll_en_out,
    output logic osc_en_out,
    output logic watchdog_en_out,
    output logic cpu_resume_out,
    output logic service_irq_out
);
    import lpm_pkg::*;

    lpm_state_t state_r; // sequencer state
    lpm_state_t state_nxt;
    logic [CTRL_USED_W-1:0] ctrl_r; // low_power_ctrl contents
    logic [MODE_W-1:0] mode_r; // mode caught at the idle instruction
    logic halve_r; // halving bit caught at the idle instruction
    logic pend_irq_r; // an interrupt caused the wake
    logic [QUAL_W:0] qual_run_r; // consecutive active wake cycles
    logic [CNT_W-1:0] hold_len; // clock hold length for this entry
    logic [CNT_W-1:0] dwell_r; // cycles spent in the current state
    logic clk_run_r; // clock pin allowed to toggle
    logic tmr_load;
    logic [CNT_W-1:0] tmr_value;
    logic tmr_expire;
    logic irq_wake; // wake sources that may need servicing
    logic any_wake; // any idle-class wake source
    logic halt_wake; // wakes seen with no clock running
    logic qual_ok; // standby wake accepted after qualification
    logic [MODE_W-1:0] mode_sel;
    logic [CNT_W-1:0] stby_lat_r; // helper: cycles since a standby wake, for checking

    // sequencer delay counter, shared by every timed state
    span_timer #(
        .W(CNT_W)
    ) u_timer (
        .clk_in(clk_sys_in),
        .srst_in(srst_in),
        .load_in(tmr_load),
        .value_in(tmr_value),
        .expire_out(tmr_expire)
    );

    assign mode_sel = ctrl_r[MODE_LSB +: MODE_W];
    assign irq_wake = wake_irq_in | watchdog_irq_in | external_nmi_in;
    assign any_wake = irq_wake | ~external_reset_pin_n_in;
    // pin sampled as a level; a real part starts on the raw edge
    assign halt_wake = ~wake_pin_n_in | ~external_reset_pin_n_in;
    assign hold_len = halve_r ? CNT_W'(HOLD_LONG) : CNT_W'(HOLD_SHORT);

    // qualified when active for 2 + count cycles in a row
    always_comb
    begin
        if (ctrl_r[QUAL_EN_BIT])
            qual_ok = any_wake && ((qual_run_r + (QUAL_W+1)'(1)) >=
                      ((QUAL_W+1)'(QUAL_BASE) + {1'b0, ctrl_r[QUAL_LSB +: QUAL_W]}));
        else
            qual_ok = any_wake;
    end

    // run length of the standby wake input
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
            qual_run_r <= '0;
        else if (state_r != ST_STBY || !any_wake)
            qual_run_r <= '0;
        else if (qual_run_r != '1)
            qual_run_r <= qual_run_r + (QUAL_W+1)'(1);
    end

    // next state and timer load
    always_comb
    begin
        state_nxt = state_r;
        tmr_load = 1'b0;
        tmr_value = '0;
        case (state_r)
            ST_RUN:
            begin
                // only a settled core may request; mode sampled now
                if (idle_exec_in)
                begin
                    if (mode_sel == MODE_IDLE)
                        state_nxt = ST_IDLE;
                    else
                    begin
                        state_nxt = ST_HOLD;
                        tmr_load = 1'b1;
                        tmr_value = ctrl_r[HALVE_BIT] ? CNT_W'(HOLD_LONG) : CNT_W'(HOLD_SHORT);
                    end
                end
            end
            ST_HOLD:
            begin
                // pipeline drain before the clock is gated
                if (tmr_expire)
                    state_nxt = (mode_r == MODE_HALT) ? ST_HALT : ST_STBY;
            end
            ST_IDLE:
            begin
                if (any_wake)
                begin
                    state_nxt = ST_RESUME;
                    tmr_load = 1'b1;
                    // the registered resume strobe adds a cycle, so load one less
                    tmr_value = CNT_W'(IDLE_RESUME - 1);
                end
            end
            ST_STBY:
            begin
                if (qual_ok)
                begin
                    state_nxt = ST_RESUME;
                    tmr_load = 1'b1;
                    tmr_value = (flash_asleep_in && !code_in_ram_in) ?
                                CNT_W'(STBY_RESUME_SLEEP - 1) : CNT_W'(STBY_RESUME_AWAKE - 1);
                end
            end
            ST_HALT:
            begin
                // waker must keep the pin low through oscillator start
                if (halt_wake)
                begin
                    state_nxt = ST_OSC;
                    tmr_load = 1'b1;
                    tmr_value = CNT_W'(OSC_START_CYCLES);
                end
            end
            ST_OSC:
            begin
                if (tmr_expire)
                begin
                    state_nxt = ST_PLL;
                    tmr_load = 1'b1;
                    tmr_value = CNT_W'(PLL_LOCK_CYCLES);
                end
            end
            ST_PLL:
            begin
                // full wait whether or not the pll is used
                if (tmr_expire)
                begin
                    state_nxt = ST_RESUME;
                    tmr_load = 1'b1;
                    tmr_value = code_in_ram_in ? CNT_W'(HALT_RESUME_RAM - 1) :
                                CNT_W'(HALT_RESUME_FLASH - 1);
                end
            end
            ST_RESUME:
            begin
                // wakes and requests are not looked at here
                if (tmr_expire)
                    state_nxt = ST_RUN;
            end
            default:
                state_nxt = ST_RUN;
        endcase
    end

    // state register
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
            state_r <= ST_RUN;
        else
            state_r <= state_nxt;
    end

    // request attributes caught when the idle instruction runs
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            mode_r <= MODE_IDLE;
            halve_r <= 1'b0;
        end
        else if (state_r == ST_RUN && idle_exec_in)
        begin
            mode_r <= mode_sel;
            halve_r <= ctrl_r[HALVE_BIT];
        end
    end

    // remember whether an interrupt woke us, so it is serviced
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
            pend_irq_r <= 1'b0;
        else if ((state_r == ST_IDLE || state_r == ST_STBY) && state_nxt == ST_RESUME)
            pend_irq_r <= irq_wake;
        else if (state_r == ST_HALT && state_nxt == ST_OSC)
            pend_irq_r <= ~wake_pin_n_in;
        else if (state_r == ST_RUN)
            pend_irq_r <= 1'b0;
    end

    // cycles in the current state, for the clock pin stop and checking
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
            dwell_r <= '0;
        else if (state_nxt != state_r)
            dwell_r <= '0;
        else if (dwell_r != '1)
            dwell_r <= dwell_r + CNT_W'(1);
    end

    // clock pin stops 32 cycles into the hold
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
            clk_run_r <= 1'b1;
        else if (state_nxt == ST_RUN || state_nxt == ST_IDLE)
            clk_run_r <= 1'b1;
        else if (state_r == ST_HOLD && dwell_r >= CNT_W'(CLKOUT_STOP_MIN - 3))
            clk_run_r <= 1'b0;
    end

    // clock pin: half rate copy of the system clock while running
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
            clock_out_pin_out <= 1'b0;
        else if (clk_run_r)
            clock_out_pin_out <= ~clock_out_pin_out;
        else
            clock_out_pin_out <= 1'b0;
    end

    // clock and oscillator enables follow the next state
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            core_clk_en_out <= 1'b1;
            periph_clk_en_out <= 1'b1;
            pll_en_out <= 1'b1;
            osc_en_out <= 1'b1;
            watchdog_en_out <= 1'b1;
        end
        else
        begin
            core_clk_en_out <= (state_nxt == ST_RUN || state_nxt == ST_HOLD);
            periph_clk_en_out <= (state_nxt == ST_RUN || state_nxt == ST_HOLD ||
                                  state_nxt == ST_IDLE);
            pll_en_out <= (state_nxt != ST_HALT && state_nxt != ST_OSC);
            // external clock sources are not ours to stop
            osc_en_out <= !(state_nxt == ST_HALT && crystal_source_in);
            watchdog_en_out <= (state_nxt != ST_HALT);
        end
    end

    // resume strobe, with interrupt service when one woke us
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
        begin
            cpu_resume_out <= 1'b0;
            service_irq_out <= 1'b0;
        end
        else
        begin
            cpu_resume_out <= (state_r == ST_RESUME && tmr_expire);
            service_irq_out <= (state_r == ST_RESUME && tmr_expire && pend_irq_r);
        end
    end

    // control register writes; undefined bits dropped
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
            ctrl_r <= CTRL_RESET;
        else if (reg_wr_in && reg_addr_in == CTRL_OFS)
            ctrl_r <= reg_wdata_in[CTRL_USED_W-1:0];
    end

    // read data one cycle after the strobe, zero otherwise
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
            reg_rdata_out <= '0;
        else if (reg_rd_in && reg_addr_in == CTRL_OFS)
            reg_rdata_out <= {{(DATA_W-CTRL_USED_W){1'b0}}, ctrl_r};
        else if (reg_rd_in && reg_addr_in == STAT_OFS)
            reg_rdata_out <= {{(DATA_W-9){1'b0}}, pend_irq_r, 2'h0, mode_r, 1'b0, state_r};
        else
            reg_rdata_out <= '0;
    end

    // checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (srst_in);

    sequence s_enter_low;
        state_r == ST_RUN && idle_exec_in && mode_sel != MODE_IDLE;
    endsequence
    sequence s_pin_quiet;
        (!clock_out_pin_out)[*8];
    endsequence

    property p_clkout_stop;
        s_enter_low |-> ##CLKOUT_STOP_MIN s_pin_quiet;
    endproperty
    a_clkout_stop: assert property (p_clkout_stop) else $error("clock pin not low in time");

    property p_hold_len;
        (state_r == ST_HOLD && state_nxt != ST_HOLD) |-> dwell_r == hold_len - CNT_W'(1);
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("clock hold length wrong");

    property p_stby_clocks;
        state_r == ST_STBY |-> !periph_clk_en_out && pll_en_out && watchdog_en_out;
    endproperty
    a_stby_clocks: assert property (p_stby_clocks) else $error("standby clock state wrong");

    property p_stby_fast;
        (state_r == ST_STBY && state_nxt == ST_RESUME && !(flash_asleep_in && !code_in_ram_in))
            |-> ##[1:100] cpu_resume_out;
    endproperty
    a_stby_fast: assert property (p_stby_fast) else $error("standby resume too slow");

    // helper: counts from the standby wake; the long bound is too far for a delay range
    always_ff @(posedge clk_sys_in)
    begin
        if (srst_in)
            stby_lat_r <= '0;
        else if (state_r == ST_STBY && state_nxt == ST_RESUME)
            stby_lat_r <= CNT_W'(1);
        else if (cpu_resume_out)
            stby_lat_r <= '0;
        else if (stby_lat_r != '0 && stby_lat_r != '1)
            stby_lat_r <= stby_lat_r + CNT_W'(1);
    end

    property p_stby_slow;
        stby_lat_r >= CNT_W'(STBY_RESUME_SLEEP) |-> cpu_resume_out;
    endproperty
    a_stby_slow: assert property (p_stby_slow) else $error("standby resume past 1125");

    property p_irq_only;
        service_irq_out |-> cpu_resume_out && $past(pend_irq_r);
    endproperty
    a_irq_only: assert property (p_irq_only) else $error("interrupt serviced without cause");

    property p_halt_off;
        state_r == ST_HALT |-> !core_clk_en_out && !periph_clk_en_out && !pll_en_out
            && (osc_en_out == !crystal_source_in);
    endproperty
    a_halt_off: assert property (p_halt_off) else $error("halt clocks not stopped");

    property p_halt_wake;
        state_r == ST_HALT && !wake_pin_n_in |=> state_r == ST_OSC && osc_en_out;
    endproperty
    a_halt_wake: assert property (p_halt_wake) else $error("wake pin ignored in halt");

    property p_pll_wait;
        (state_r == ST_PLL && state_nxt != ST_PLL) |-> dwell_r == CNT_W'(PLL_LOCK_CYCLES - 1);
    endproperty
    a_pll_wait: assert property (p_pll_wait) else $error("pll lock wait wrong");

    property p_halt_resume;
        (state_r == ST_PLL && state_nxt == ST_RESUME && code_in_ram_in) |-> ##35 cpu_resume_out;
    endproperty
    a_halt_resume: assert property (p_halt_resume) else $error("halt ram resume wrong");

    property p_run_clocks;
        state_r == ST_RUN |-> core_clk_en_out && periph_clk_en_out;
    endproperty
    a_run_clocks: assert property (p_run_clocks) else $error("clocks off while running");

    property p_idle_wake;
        state_r == ST_IDLE && watchdog_irq_in |=> state_r == ST_RESUME;
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("watchdog did not wake");

    property p_mode_catch;
        state_r == ST_RUN && idle_exec_in |=> mode_r == $past(mode_sel);
    endproperty
    a_mode_catch: assert property (p_mode_catch) else $error("mode not sampled");

    property p_no_rewake;
        state_r == ST_RESUME |=> state_r == ST_RESUME || state_r == ST_RUN;
    endproperty
    a_no_rewake: assert property (p_no_rewake) else $error("resume sequence broken");
endmodule

// >>> wake_pin_driver.sv
`timescale 1ns/1ps
// far side of the sequencer: the party that wakes the device from halt
// both pins have pull-ups, so a released pin reads high
module wake_pin_driver #(
    parameter int OSC_START = 8
) (
    input wire logic clk_in,
    input wire logic pin_req_in,
    input wire logic rst_req_in,
    output logic wake_pin_n_out,
    output logic reset_n_out
);
    int pin_left = 0; // cycles the wake pin is still held low
    int rst_left = 0; // cycles the reset pin is still held low
    // pin held until the oscillator settles plus two cycles, one spare
    always @(posedge clk_in)
    begin
        if (pin_req_in)
            pin_left <= OSC_START + 3;
        else if (pin_left > 0)
            pin_left <= pin_left - 1;
    end
    // reset held until the oscillator settles plus eight cycles, one spare
    always @(posedge clk_in)
    begin
        if (rst_req_in)
            rst_left <= OSC_START + 9;
        else if (rst_left > 0)
            rst_left <= rst_left - 1;
    end
    assign wake_pin_n_out = (pin_left == 0);
    assign reset_n_out = (rst_left == 0);
endmodule

// >>> tb_low_power_mode_sequencer.sv
`timescale 1ns/1ps
module tb_low_power_mode_sequencer;
    import lpm_pkg::*;
    localparam int PLL_T = 16; // shortened lock wait keeps the run brief
    localparam int OSC_T = 8; // shortened oscillator start
    logic clk_sys_in = 1'b0;
    logic srst_in = 1'b1;
    logic [ADDR_W-1:0] reg_addr = 8'h00;
    logic [DATA_W-1:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic idle_exec = 1'b0;
    logic wake_irq = 1'b0;
    logic wd_irq = 1'b0;
    logic nmi = 1'b0;
    logic flash_sleep = 1'b0;
    logic in_ram = 1'b0;
    logic xtal = 1'b0;
    logic pin_req = 1'b0;
    logic rst_req = 1'b0;
    wire logic rst_n;
    wire logic pin_n;
    logic clk_pin, core_en, per_en, pll_en, osc_en, wd_en, resume, service;
    int fail_count = 0;
    int comparisons = 0;
    logic [31:0] rd_val;

    low_power_mode_sequencer #(.PLL_LOCK_CYCLES(PLL_T), .OSC_START_CYCLES(OSC_T)) dut (
        .clk_sys_in(clk_sys_in), .srst_in(srst_in), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(reg_rdata), .idle_exec_in(idle_exec), .wake_irq_in(wake_irq),
        .watchdog_irq_in(wd_irq), .external_nmi_in(nmi), .external_reset_pin_n_in(rst_n),
        .wake_pin_n_in(pin_n), .flash_asleep_in(flash_sleep), .code_in_ram_in(in_ram),
        .crystal_source_in(xtal), .clock_out_pin_out(clk_pin), .core_clk_en_out(core_en),
        .periph_clk_en_out(per_en), .pll_en_out(pll_en), .osc_en_out(osc_en),
        .watchdog_en_out(wd_en), .cpu_resume_out(resume), .service_irq_out(service));

    wake_pin_driver #(.OSC_START(OSC_T)) waker (
        .clk_in(clk_sys_in), .pin_req_in(pin_req), .rst_req_in(rst_req),
        .wake_pin_n_out(pin_n), .reset_n_out(rst_n));

    // 40 MHz system clock
    initial
    begin
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end

    // verdict and end of run, reached from the main flow or the hang guard
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    // one-cycle write strobe; the slave never stalls
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys_in);
        reg_wr <= 1'b0;
    endtask

    // read data stands only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_sys_in);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys_in);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    // idle request, then a stray request, wake and mode rewrite while holding
    task automatic enter(input logic [31:0] ctrl, input int hold_exp);
        int k;
        int hold;
        logic hi_early;
        logic lo_late;
        hold = 0;
        hi_early = 1'b0;
        lo_late = 1'b1;
        reg_write(CTRL_OFS, ctrl);
        @(posedge clk_sys_in);
        idle_exec <= 1'b1;
        @(posedge clk_sys_in);
        idle_exec <= 1'b0;
        for (k = 1; k <= 70; k++)
        begin
            @(posedge clk_sys_in);
            reg_wr <= (k == 2);
            idle_exec <= (k == 2);
            wake_irq <= (k == 2);
            reg_addr <= CTRL_OFS;
            reg_wdata <= ctrl & 32'hFFFF_FFFC;
            #1;
            if (k < 31 && clk_pin === 1'b1)
                hi_early = 1'b1;
            if (k >= 45 && clk_pin !== 1'b0)
                lo_late = 1'b0;
            if (hold == 0 && per_en === 1'b0)
                hold = k;
        end
        check("hold length", 32'(hold), 32'(hold_exp));
        check("pin runs early", 32'(hi_early), 32'h1);
        check("pin low late", 32'(lo_late), 32'h1);
    endtask

    // counts edges from the wake until execution resumes
    task automatic wait_resume(input int lo, input int hi, input logic svc,
                               output logic osc2, output logic pll_mid);
        int k;
        osc2 = 1'b0;
        pll_mid = 1'b0;
        for (k = 1; k <= 3000; k++)
        begin
            @(posedge clk_sys_in);
            #1;
            if (k == 2)
                osc2 = osc_en;
            if (k == 2 + OSC_T + PLL_T / 2)
                pll_mid = pll_en;
            if (resume === 1'b1)
                break;
        end
        if (k > 3000)
        begin
            fail_count++;
            end_sim();
        end
        check("resume latency", 32'(k >= lo && k <= hi), 32'h1);
        check("service pulse", 32'(service), 32'(svc));
        @(posedge clk_sys_in);
        #1;
        check("clocks back", 32'({core_en, per_en}), 32'h3);
    endtask

    // hang guard: a stuck run still ends with a verdict
    initial
    begin
        #(SYS_PERIOD_NS * 100000);
        fail_count++;
        end_sim();
    end

    initial
    begin
        int s;
        logic osc2;
        logic pll_mid;
        repeat (20) @(posedge clk_sys_in);
        srst_in <= 1'b0;
        @(posedge clk_sys_in);
        #1;
        check("reset enables", 32'({core_en, per_en, pll_en, osc_en, wd_en}), 32'h1F);
        reg_write(8'h10, 32'hFFFF_FFFF);
        reg_read(CTRL_OFS, rd_val);
        check("ctrl reset", rd_val, 32'h0);
        reg_read(8'h10, rd_val);
        check("unmapped", rd_val, 32'h0);
        reg_read(STAT_OFS, rd_val);
        check("status run", rd_val & 32'h37, 32'h0);
        reg_write(CTRL_OFS, 32'hFFFF_FFFF);
        reg_read(CTRL_OFS, rd_val);
        check("ctrl width", rd_val, 32'h3FF);
        $display("test registers done");

        // standby, flash awake; the stray requests in hold change nothing
        enter(32'h001, HOLD_SHORT);
        check("standby clocks", 32'({core_en, per_en, pll_en, wd_en}), 32'h3);
        reg_read(STAT_OFS, rd_val);
        check("standby status", rd_val & 32'h37, 32'h13);
        @(posedge clk_sys_in);
        wake_irq <= 1'b1;
        wait_resume(100, 102, 1'b1, osc2, pll_mid);
        @(posedge clk_sys_in);
        wake_irq <= 1'b0;
        $display("test standby done");

        // standby with qualification 3 and sleeping flash
        flash_sleep <= 1'b1;
        enter(32'h10D, HOLD_SHORT);
        @(posedge clk_sys_in);
        wake_irq <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        wake_irq <= 1'b0;
        repeat (10) @(posedge clk_sys_in);
        #1;
        check("short wake ignored", 32'(per_en), 32'h0);
        @(posedge clk_sys_in);
        wake_irq <= 1'b1;
        wait_resume(1125, 1132, 1'b1, osc2, pll_mid);
        @(posedge clk_sys_in);
        wake_irq <= 1'b0;
        flash_sleep <= 1'b0;
        $display("test qualified standby done");

        // halt from crystal with halved input, code in ram, wake by pin
        xtal <= 1'b1;
        in_ram <= 1'b1;
        enter(32'h202, HOLD_LONG);
        check("halt clocks", 32'({core_en, per_en, pll_en, osc_en}), 32'h0);
        @(posedge clk_sys_in);
        pin_req <= 1'b1;
        @(posedge clk_sys_in);
        pin_req <= 1'b0;
        wait_resume(58, 63, 1'b1, osc2, pll_mid);
        check("osc restarted", 32'(osc2), 32'h1);
        check("pll during lock", 32'(pll_mid), 32'h1);
        xtal <= 1'b0;
        $display("test halt done");

        // idle mode woken by each source in turn
        reg_write(CTRL_OFS, 32'h000);
        for (s = 0; s < 4; s++)
        begin
            @(posedge clk_sys_in);
            idle_exec <= 1'b1;
            @(posedge clk_sys_in);
            idle_exec <= 1'b0;
            @(posedge clk_sys_in);
            #1;
            check("idle clocks", 32'({core_en, per_en}), 32'h1);
            @(posedge clk_sys_in);
            wake_irq <= (s == 0);
            wd_irq <= (s == 1);
            nmi <= (s == 2);
            rst_req <= (s == 3);
            if (s == 3)
            begin
                @(posedge clk_sys_in);
                rst_req <= 1'b0;
            end
            wait_resume(20, 22, s != 3, osc2, pll_mid);
            @(posedge clk_sys_in);
            wake_irq <= 1'b0;
            wd_irq <= 1'b0;
            nmi <= 1'b0;
        end
        repeat (20) @(posedge clk_sys_in);
        $display("test idle wake sources done");
        end_sim();
    end
endmodule
